/* verilog/synth_cfg_device.sv */
// synthesizer end: config words, modulator reset delay, frame sync generator, output divider
`timescale 1ns/100ps
`default_nettype none
module synth_cfg_device (
   input  wire logic            clk_sys_in,
   input  wire logic            nrst_in,
   synth_cfg_if.device          link,
   input  wire logic [2:0]      cal_clk_div_in,
   input  wire logic            phase_sync_start_in,
   output logic                 sync_busy_out,
   output logic                 sync_done_out,
   output logic                 output_clk_out,
   output logic [7:0]           output_divide_ratio_out,
   output logic                 frame_sync_out,
   output logic [5:0]           frame_sync_delay_one_out,
   output logic [5:0]           frame_sync_delay_two_out,
   output logic [5:0]           frame_sync_delay_three_out,
   output logic [5:0]           frame_sync_delay_four_out
);
   import synth_cfg_pkg::*;

   dev_state_t  s_r;
   dev_state_t  s_nxt;
   logic [3:0]  idx;
   logic        hit;
   logic        sm_tick;
   logic [6:0]  sm_limit;
   logic [31:0] delay_count;
   logic [7:0]  ratio;
   logic        out_tick;
   logic [2:0]  pre_ratio;
   logic        pre_wrap;
   logic [10:0] main_ratio;
   logic        main_wrap;
   logic        boundary;
   logic        req_rise;
   logic [4:0]  burst_len;
   word_t       w_ctrl;

   // channel divider code to divide ratio; undefined codes fall back to 2
   function automatic logic [7:0] ratio_of(input logic [4:0] code);
      logic [7:0] r;
      r = 8'h02;
      unique case (code)
         5'h00:   r = 8'h02;
         5'h01:   r = 8'h04;
         5'h02:   r = 8'h06;
         5'h03:   r = 8'h08;
         5'h04:   r = 8'h0C;
         5'h05:   r = 8'h10;
         5'h06:   r = 8'h18;
         5'h07:   r = 8'h20;
         5'h08:   r = 8'h30;
         5'h09:   r = 8'h40;
         5'h0A:   r = 8'h60;
         5'h0B:   r = 8'h80;
         5'h0C:   r = 8'hC0;
         default: r = 8'h02;
      endcase
      return r;
   endfunction

   // prescaler code to ratio; other codes act as divide by 4
   function automatic logic [2:0] pre_of(input logic [2:0] code);
      logic [2:0] r;
      r = (code == `PRE_CODE_DIV2) ? 3'h2 : 3'h4;
      return r;
   endfunction

   function automatic word_t reset_word(input logic [3:0] i);
      word_t w;
      w = `RST_RSV_A;
      unique case (i)
         4'h0:    w = `RST_RSV_A;
         4'h1:    w = `RST_RSV_B;
         4'h2:    w = `RST_RSV_C;
         4'h3:    w = `RST_CNT_HIGH;
         4'h4:    w = `RST_CNT_LOW;
         4'h5:    w = `RST_FS_CTRL;
         4'h6:    w = `RST_FS_DIV;
         4'h7:    w = `RST_FS_DLY_A;
         4'h8:    w = `RST_FS_DLY_B;
         4'h9:    w = `RST_OUT_DIV;
         default: w = 16'h0000;
      endcase
      return w;
   endfunction

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.sync_done = 1'b0;
      s_nxt.fs_out = 1'b0;
      w_ctrl = s_r.regs[`OFS_FS_CTRL - `OFS_RSV_A];

      // link access: one answer per request, answered the cycle after it is seen
      hit = (link.addr >= `OFS_RSV_A) && (link.addr < (`OFS_RSV_A + 7'(`NUM_WORDS)));
      idx = 4'(link.addr - `OFS_RSV_A);
      if (link.req && !s_r.ack)
      begin
         s_nxt.ack = 1'b1;
         s_nxt.rdata = hit ? s_r.regs[idx] : 16'h0000;
         if (hit && link.we)
         begin
            s_nxt.regs[idx] = link.wdata;
         end
      end

      // state machine clock: one tick per 2^div reference cycles
      sm_limit = 7'((8'h01 << cal_clk_div_in) - 8'h01);
      sm_tick = (s_r.sm_div >= sm_limit);
      s_nxt.sm_div = sm_tick ? 7'h00 : s_r.sm_div + 7'h01;

      delay_count = {s_r.regs[`OFS_CNT_HIGH - `OFS_RSV_A],
                     s_r.regs[`OFS_CNT_LOW - `OFS_RSV_A]};
      unique case (s_r.sst)
         SYNC_IDLE:
         begin
            if (phase_sync_start_in)
            begin
               s_nxt.sync_cnt = delay_count;
               s_nxt.sst = SYNC_WAIT;
            end
         end
         SYNC_WAIT:
         begin
            if (sm_tick)
            begin
               if (s_r.sync_cnt == 32'h0000_0000)
               begin
                  s_nxt.sync_done = 1'b1;
                  s_nxt.sst = SYNC_IDLE;
               end
               else
               begin
                  s_nxt.sync_cnt = s_r.sync_cnt - 32'h0000_0001;
               end
            end
         end
      endcase

      // output divider; ratio taken live, so a code change shortens or stretches one period at most
      ratio = ratio_of(s_r.regs[`OFS_OUT_DIV - `OFS_RSV_A][`RATIO_HI:`RATIO_LO]);
      out_tick = (s_r.ch_cnt >= ratio - 8'h01);
      s_nxt.ch_cnt = out_tick ? 8'h00 : s_r.ch_cnt + 8'h01;
      s_nxt.out_clk = (s_nxt.ch_cnt < (ratio >> 1));

      // frame sync period = output period * prescaler * main divider
      pre_ratio = pre_of(w_ctrl[`PRE_HI:`PRE_LO]);
      main_ratio = s_r.regs[`OFS_FS_DIV - `OFS_RSV_A][`MAIN_DIV_HI:0];
      if (main_ratio == 11'h000)
      begin
         main_ratio = 11'h001;
      end
      pre_wrap = (s_r.pre_cnt >= pre_ratio - 3'h1);
      main_wrap = (s_r.main_cnt >= main_ratio - 11'h001);
      boundary = out_tick && pre_wrap && main_wrap;
      if (out_tick)
      begin
         s_nxt.pre_cnt = pre_wrap ? 3'h0 : s_r.pre_cnt + 3'h1;
         if (pre_wrap)
         begin
            s_nxt.main_cnt = main_wrap ? 11'h000 : s_r.main_cnt + 11'h001;
         end
      end

      // request pin is synchronous, so a single past sample finds the rise
      req_rise = link.frame_sync_request_pin && !s_r.req_prev;
      s_nxt.req_prev = link.frame_sync_request_pin;
      burst_len = {1'b0, s_r.regs[`OFS_FS_DLY_B - `OFS_RSV_A][`BURST_LEN_HI:`BURST_LEN_LO]};
      if (burst_len == 5'h00)
      begin
         burst_len = 5'h10;
      end

      if (boundary && s_r.burst_left != 5'h00)
      begin
         s_nxt.fs_out = 1'b1;
         s_nxt.burst_left = s_r.burst_left - 5'h01;
      end
      if (!w_ctrl[`GEN_ON_BIT])
      begin
         s_nxt.burst_left = 5'h00;
      end
      else if (w_ctrl[`MODE_BIT])
      begin
         if (req_rise)
         begin
            s_nxt.burst_left = 5'h01;
         end
      end
      else if (w_ctrl[`BURST_BIT])
      begin
         if (req_rise)
         begin
            s_nxt.burst_left = burst_len;
         end
      end
      else
      begin
         s_nxt.burst_left = 5'h00;
         s_nxt.fs_out = boundary;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s_r <= '0;
         for (int i = 0; i < 10; i++)
         begin
            s_r.regs[i] <= reset_word(4'(i));
         end
         s_r.sst <= SYNC_IDLE;
         s_r.out_clk <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign link.ack = s_r.ack;
   assign link.rdata = s_r.rdata;
   assign sync_busy_out = (s_r.sst == SYNC_WAIT);
   assign sync_done_out = s_r.sync_done;
   assign output_clk_out = s_r.out_clk;
   assign output_divide_ratio_out = ratio;
   assign frame_sync_out = s_r.fs_out;
   assign frame_sync_delay_one_out = s_r.regs[`OFS_FS_DLY_A - `OFS_RSV_A][`DLY_LO_HI:0];
   assign frame_sync_delay_two_out =
      s_r.regs[`OFS_FS_DLY_A - `OFS_RSV_A][`DLY_HI_HI:`DLY_HI_LO];
   assign frame_sync_delay_three_out = s_r.regs[`OFS_FS_DLY_B - `OFS_RSV_A][`DLY_LO_HI:0];
   assign frame_sync_delay_four_out =
      s_r.regs[`OFS_FS_DLY_B - `OFS_RSV_A][`DLY_HI_HI:`DLY_HI_LO];
endmodule
`default_nettype wire

/* verilog/synth_cfg_map.svh */
// offsets, field positions, reset values and fixed words of the synthesizer config block
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH

// device word offsets on the configuration link
`define OFS_RSV_A        7'h42
`define OFS_RSV_B        7'h43
`define OFS_RSV_C        7'h44
`define OFS_CNT_HIGH     7'h45
`define OFS_CNT_LOW      7'h46
`define OFS_FS_CTRL      7'h47
`define OFS_FS_DIV       7'h48
`define OFS_FS_DLY_A     7'h49
`define OFS_FS_DLY_B     7'h4A
`define OFS_OUT_DIV      7'h4B
`define NUM_WORDS        4'hA

// device reset values
`define RST_RSV_A        16'h0140
`define RST_RSV_B        16'h0000
`define RST_RSV_C        16'h03E8
`define RST_CNT_HIGH     16'h0000
`define RST_CNT_LOW      16'hC350
`define RST_FS_CTRL      16'h0080
`define RST_FS_DIV       16'h0001
`define RST_FS_DLY_A     16'h003F
`define RST_FS_DLY_B     16'h0000
`define RST_OUT_DIV      16'h0800

// field positions
`define PRE_HI           7
`define PRE_LO           5
`define BURST_BIT        4
`define GEN_ON_BIT       3
`define MODE_BIT         2
`define MAIN_DIV_HI      10
`define DLY_HI_HI        11
`define DLY_HI_LO        6
`define DLY_LO_HI        5
`define BURST_LEN_HI     15
`define BURST_LEN_LO     12
`define RATIO_HI         10
`define RATIO_LO         6
`define RATIO_CODE_MAX   5'h0C
`define PRE_CODE_DIV2    3'h2
`define PRE_CODE_DIV4    3'h4

// values the host must place in reserved words and fields
`define REQ_RSV_A        16'h01F4
`define REQ_RSV_B        16'h0000
`define REQ_RSV_C        16'h03E8
`define REQ_OUT_DIV_HI   5'h01
`define RSV_MASK_CTRL    16'hFF03
`define RSV_MASK_DIV     16'hF800
`define RSV_MASK_DLY_A   16'hF000
`define RSV_MASK_OUT_DIV 16'hF83F
`define INIT_STEPS       3'h4

// host register map on APB (byte addresses)
`define APB_CMD          8'h00
`define APB_STATUS       8'h04
`define APB_CTRL         8'h08
`define CMD_READ_BIT     31
`define ST_BUSY_BIT      0
`define ST_RATIO_ERR_BIT 1
`define ST_CNT_LOW_BIT   2
`define CTRL_REQ_PIN_BIT 0
`define CTRL_INIT_BIT    1
`define MIN_SYNC_COUNT   32'h0000_0100

`endif

/* verilog/synth_cfg_pkg.sv */
// types shared by both ends of the synthesizer configuration link
`default_nettype none
`include "synth_cfg_map.svh"
package synth_cfg_pkg;
   typedef logic [6:0]  link_addr_t;
   typedef logic [15:0] word_t;

   typedef enum logic [0:0] {
      SYNC_IDLE = 1'b0,
      SYNC_WAIT = 1'b1
   } sync_state_t;

   typedef struct packed {
      word_t [9:0] regs;
      logic        ack;
      word_t       rdata;
      logic        req_prev;
      sync_state_t sst;
      logic [31:0] sync_cnt;
      logic [6:0]  sm_div;
      logic        sync_done;
      logic [7:0]  ch_cnt;
      logic        out_clk;
      logic [2:0]  pre_cnt;
      logic [10:0] main_cnt;
      logic [4:0]  burst_left;
      logic        fs_out;
   } dev_state_t;

   typedef struct packed {
      logic        busy;
      logic        req;
      logic        we;
      link_addr_t  addr;
      word_t       wdata;
      word_t       last_rd;
      logic        ratio_err;
      word_t       cnt_high;
      word_t       cnt_low;
      logic        init_run;
      logic [2:0]  init_step;
      logic        req_pin;
   } host_state_t;
endpackage
`default_nettype wire

/* verilog/synth_cfg_if.sv */
// configuration link between host controller and synthesizer
`timescale 1ns/100ps
`default_nettype none
interface synth_cfg_if;
   logic        req;
   logic        we;
   logic [6:0]  addr;
   logic [15:0] wdata;
   logic        ack;
   logic [15:0] rdata;
   logic        frame_sync_request_pin;

   modport device (
      input  req,
      input  we,
      input  addr,
      input  wdata,
      input  frame_sync_request_pin,
      output ack,
      output rdata
   );

   modport host (
      output req,
      output we,
      output addr,
      output wdata,
      output frame_sync_request_pin,
      input  ack,
      input  rdata
   );
endinterface
`default_nettype wire

/* verilog/synth_cfg_host.sv */
// host end: APB command registers driving the synthesizer configuration link
`timescale 1ns/100ps
`default_nettype none
module synth_cfg_host (
   input  wire logic            clk_sys_in,
   input  wire logic            nrst_in,
   input  wire logic [7:0]      paddr,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   synth_cfg_if.host            link
);
   import synth_cfg_pkg::*;

   host_state_t h_r;
   host_state_t h_nxt;
   logic        access;
   logic        cmd_wr;
   logic        ctrl_wr;
   logic        stat_wr;
   logic        mapped;
   link_addr_t  c_addr;
   word_t       c_data;
   logic [23:0] init_w;
   logic [23:0] init_0;

   // power-up words for reserved locations: {addr, data, spare bit}
   function automatic logic [23:0] init_word(input logic [2:0] step);
      logic [23:0] w;
      w = {`OFS_RSV_A, `REQ_RSV_A, 1'b0};
      unique case (step)
         3'h0:    w = {`OFS_RSV_A, `REQ_RSV_A, 1'b0};
         3'h1:    w = {`OFS_RSV_B, `REQ_RSV_B, 1'b0};
         3'h2:    w = {`OFS_RSV_C, `REQ_RSV_C, 1'b0};
         default: w = {`OFS_OUT_DIV, `REQ_OUT_DIV_HI, 11'h000, 1'b0};
      endcase
      return w;
   endfunction

   // software data is trusted for fields, reserved bits are forced
   function automatic word_t fix_word(input link_addr_t a, input word_t d);
      word_t w;
      w = d;
      unique case (a)
         `OFS_RSV_A:   w = `REQ_RSV_A;
         `OFS_RSV_B:   w = `REQ_RSV_B;
         `OFS_RSV_C:   w = `REQ_RSV_C;
         `OFS_FS_CTRL: w = d & ~`RSV_MASK_CTRL;
         `OFS_FS_DIV:  w = d & ~`RSV_MASK_DIV;
         `OFS_FS_DLY_A: w = d & ~`RSV_MASK_DLY_A;
         `OFS_OUT_DIV: w = (d & ~`RSV_MASK_OUT_DIV) | {`REQ_OUT_DIV_HI, 11'h000};
         default:      w = d;
      endcase
      return w;
   endfunction

   always_comb
   begin
      h_nxt = h_r;
      init_w = init_word(h_r.init_step + 3'h1);
      init_0 = init_word(3'h0);
      c_addr = pwdata[22:16];
      c_data = pwdata[15:0];
      mapped = (paddr == `APB_CMD) || (paddr == `APB_STATUS) || (paddr == `APB_CTRL);
      // a command or control write while busy stalls the bus until the link is free
      pready = !(psel && pwrite && h_r.busy && (paddr == `APB_CMD || paddr == `APB_CTRL));
      access = psel && penable && pready;
      cmd_wr = access && pwrite && (paddr == `APB_CMD);
      ctrl_wr = access && pwrite && (paddr == `APB_CTRL);
      stat_wr = access && pwrite && (paddr == `APB_STATUS);
      pslverr = psel && penable && !mapped;
      prdata = 32'h0000_0000;
      if (paddr == `APB_STATUS)
      begin
         prdata = {h_r.last_rd, 13'h0000,
                   ({h_r.cnt_high, h_r.cnt_low} < `MIN_SYNC_COUNT),
                   h_r.ratio_err, h_r.busy};
      end
      else if (paddr == `APB_CTRL)
      begin
         prdata = {30'h0000_0000, h_r.init_run, h_r.req_pin};
      end

      if (stat_wr && pwdata[`ST_RATIO_ERR_BIT])
      begin
         h_nxt.ratio_err = 1'b0;
      end
      if (ctrl_wr)
      begin
         h_nxt.req_pin = pwdata[`CTRL_REQ_PIN_BIT];
         if (pwdata[`CTRL_INIT_BIT])
         begin
            h_nxt.init_run = 1'b1;
            h_nxt.init_step = 3'h0;
            h_nxt.busy = 1'b1;
            h_nxt.req = 1'b1;
            h_nxt.we = 1'b1;
            {h_nxt.addr, h_nxt.wdata} = init_0[23:1];
         end
      end
      if (cmd_wr)
      begin
         if (!pwdata[`CMD_READ_BIT] && c_addr == `OFS_OUT_DIV
             && c_data[`RATIO_HI:`RATIO_LO] > `RATIO_CODE_MAX)
         begin
            h_nxt.ratio_err = 1'b1;
         end
         else
         begin
            h_nxt.busy = 1'b1;
            h_nxt.req = 1'b1;
            h_nxt.we = !pwdata[`CMD_READ_BIT];
            h_nxt.addr = c_addr;
            h_nxt.wdata = fix_word(c_addr, c_data);
            if (!pwdata[`CMD_READ_BIT] && c_addr == `OFS_CNT_HIGH)
            begin
               h_nxt.cnt_high = c_data;
            end
            if (!pwdata[`CMD_READ_BIT] && c_addr == `OFS_CNT_LOW)
            begin
               h_nxt.cnt_low = c_data;
            end
         end
      end

      if (h_r.req && link.ack)
      begin
         h_nxt.last_rd = link.rdata;
         if (h_r.init_run && h_r.init_step < `INIT_STEPS - 3'h1)
         begin
            h_nxt.init_step = h_r.init_step + 3'h1;
            {h_nxt.addr, h_nxt.wdata} = init_w[23:1];
         end
         else
         begin
            h_nxt.req = 1'b0;
            h_nxt.busy = 1'b0;
            h_nxt.init_run = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         h_r <= '0;
         h_r.cnt_high <= `RST_CNT_HIGH;
         h_r.cnt_low <= `RST_CNT_LOW;
      end
      else
      begin
         h_r <= h_nxt;
      end
   end

   assign link.req = h_r.req;
   assign link.we = h_r.we;
   assign link.addr = h_r.addr;
   assign link.wdata = h_r.wdata;
   assign link.frame_sync_request_pin = h_r.req_pin;
endmodule
`default_nettype wire

/* verification/synth_cfg_properties.sv */
// link protocol and reserved-field checks between the host and synthesizer ends
`timescale 1ns/100ps
`default_nettype none
`include "synth_cfg_map.svh"
module synth_cfg_properties (
   input wire logic        clk_sys_in,
   input wire logic        nrst_in,
   input wire logic        req,
   input wire logic        we,
   input wire logic [6:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        ack,
   input wire logic [15:0] rdata,
   input wire logic        frame_sync_request_pin
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);
   logic wr;
   assign wr = req && we;
   sequence s_take;
      req && !ack;
   endsequence
   sequence s_answer;
      ack ##1 !ack;
   endsequence
   property p_answer;
      s_take |=> s_answer;
   endproperty
   property p_cause;
      ack |-> $past(req) && !$past(ack);
   endproperty
   property p_hold;
      s_take |=> req && $stable(addr) && $stable(we) && $stable(wdata);
   endproperty
   property p_unmapped;
      ack && !we && (addr < `OFS_RSV_A || addr > `OFS_OUT_DIV) |-> rdata == 16'h0000;
   endproperty
   property p_rsv_a;
      wr && addr == `OFS_RSV_A |-> wdata == `REQ_RSV_A;
   endproperty
   property p_rsv_c;
      wr && addr == `OFS_RSV_C |-> wdata == `REQ_RSV_C;
   endproperty
   property p_out_div_hi;
      wr && addr == `OFS_OUT_DIV |-> wdata[15:11] == `REQ_OUT_DIV_HI;
   endproperty
   property p_rsv_zero;
      wr |-> (addr == `OFS_RSV_B ? wdata : addr == `OFS_FS_CTRL ? wdata & `RSV_MASK_CTRL :
              addr == `OFS_FS_DIV ? wdata & `RSV_MASK_DIV : addr == `OFS_FS_DLY_A ?
              wdata & `RSV_MASK_DLY_A : addr == `OFS_OUT_DIV ? wdata & 16'h003F :
              16'h0000) == 16'h0000;
   endproperty
   property p_ratio_code;
      wr && addr == `OFS_OUT_DIV |-> wdata[10:6] <= `RATIO_CODE_MAX;
   endproperty
   a_answer: assert property (p_answer) else $error("link answer not one cycle after take");
   a_cause: assert property (p_cause) else $error("link answer without a request");
   a_hold: assert property (p_hold) else $error("link request changed before answer");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read gave nonzero data");
   a_rsv_a: assert property (p_rsv_a) else $error("wrong value sent to reserved word a");
   a_rsv_c: assert property (p_rsv_c) else $error("wrong value sent to reserved word c");
   a_out_div_hi: assert property (p_out_div_hi) else $error("divider word top bits wrong");
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved field sent nonzero");
   a_ratio_code: assert property (p_ratio_code) else $error("undefined divider code sent");
   c_pin_rise: cover property ($rose(frame_sync_request_pin));
endmodule
`default_nettype wire

/* verification/sysref_and_output_divider_config_test.sv */
// self-checking bench: APB drives the host end, which programs the synthesizer end
`timescale 1ns/100ps
`default_nettype none
`include "synth_cfg_map.svh"
module sysref_and_output_divider_config_test;
   import synth_cfg_pkg::*;
   logic        clk_sys_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  cal_div = 3'h0;
   logic        sync_start = 1'b0;
   logic        sync_busy;
   logic        sync_done;
   logic [7:0]  ratio;
   logic        fs_out;
   logic        out_clk;
   logic [5:0]  dly [4];
   logic [31:0] rd;
   logic        err;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          fs_cnt = 0;
   int          k;
   int          n;
   int          f0;
   logic [15:0] rst_tab [10] = '{16'h0140, 16'h0000, 16'h03E8, 16'h0000, 16'hC350, 16'h0080,
                                 16'h0001, 16'h003F, 16'h0000, 16'h0800};
   logic [7:0]  div_tab [13] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h30,
                                 8'h40, 8'h60, 8'h80, 8'hC0};
   logic [6:0]  frc_a [7] = '{7'h42, 7'h44, 7'h43, 7'h47, 7'h48, 7'h49, 7'h4B};
   logic [15:0] frc_w [7] = '{16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hF8FF};
   logic [15:0] frc_e [7] = '{16'h01F4, 16'h03E8, 16'h0000, 16'h00FC, 16'h07FF, 16'h0FFF, 16'h08C0};

   synth_cfg_if u_synth_cfg_if ();
   synth_cfg_host u_synth_cfg_host (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(u_synth_cfg_if));
   synth_cfg_device u_synth_cfg_device (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .link(u_synth_cfg_if), .cal_clk_div_in(cal_div), .phase_sync_start_in(sync_start),
      .sync_busy_out(sync_busy), .sync_done_out(sync_done), .output_clk_out(out_clk),
      .output_divide_ratio_out(ratio), .frame_sync_out(fs_out),
      .frame_sync_delay_one_out(dly[0]), .frame_sync_delay_two_out(dly[1]),
      .frame_sync_delay_three_out(dly[2]), .frame_sync_delay_four_out(dly[3]));
   synth_cfg_properties u_synth_cfg_properties (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
      .req(u_synth_cfg_if.req), .we(u_synth_cfg_if.we), .addr(u_synth_cfg_if.addr),
      .wdata(u_synth_cfg_if.wdata), .ack(u_synth_cfg_if.ack), .rdata(u_synth_cfg_if.rdata),
      .frame_sync_request_pin(u_synth_cfg_if.frame_sync_request_pin));

   initial
   begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // pulses are one cycle wide, so a plain edge count is exact
   always @(posedge clk_sys_in)
      if (fs_out === 1'b1)
         fs_cnt <= fs_cnt + 1;

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1)
         @(posedge clk_sys_in);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_in);
   endtask

   // one word across the link; afterwards rd holds status with the last read data on top
   task automatic link(input logic [6:0] a, input logic w, input logic [15:0] d);
      apb(`APB_CMD, 1'b1, {~w, 8'h00, a, d});
      for (int i = 0; i < 50; i++)
      begin
         apb(`APB_STATUS, 1'b0, 32'h0000_0000);
         if (rd[0] === 1'b0)
            break;
      end
   endtask

   task automatic sync_run(input logic [2:0] d, input int cnt);
      cal_div <= d;
      sync_start <= 1'b1;
      @(posedge clk_sys_in);
      sync_start <= 1'b0;
      @(posedge clk_sys_in);
      check("sync busy", 1, sync_busy);
      n = 1;
      while (sync_done !== 1'b1 && n < 300)
      begin
         @(posedge clk_sys_in);
         n++;
      end
      check("sync delay in span", 1, n >= (cnt << d) && n <= ((cnt + 1) << d) + 2);
   endtask

   task automatic period(input int exp);
      for (int i = 0; i < 3; i++)
      begin
         f0 = fs_cnt;
         n = 0;
         while (fs_cnt == f0 && n < 400)
         begin
            @(posedge clk_sys_in);
            n++;
         end
      end
      check("frame sync period", exp, n);
   endtask

   task automatic pulses(input int cyc, input int exp);
      repeat (cyc) @(posedge clk_sys_in);
      check("frame sync pulses", exp, fs_cnt - f0);
   endtask

   initial
   begin
      #200000;
      n_errors++;
      results();
   end

   initial
   begin
      repeat (20) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(posedge clk_sys_in);
      check("ratio at reset", 8'h02, ratio);
      check("delay one at reset", 6'h3F, dly[0]);
      check("output clock at reset", 1, out_clk);
      @(posedge clk_sys_in);
      check("output clock toggled", 0, out_clk);
      for (k = 0; k < 10; k++)
      begin
         link(7'h42 + 7'(k), 1'b0, 16'h0000);
         check("word reset value", rst_tab[k], rd[31:16]);
      end
      f0 = fs_cnt;
      pulses(60, 0);
      $display("test reset values done");
      for (k = 0; k < 7; k++)
      begin
         link(frc_a[k], 1'b1, frc_w[k]);
         link(frc_a[k], 1'b0, 16'h0000);
         check("forced reserved bits", frc_e[k], rd[31:16]);
      end
      apb(`APB_CTRL, 1'b1, 32'h0000_0002);
      rd = 32'h0000_0002;
      for (k = 0; k < 50 && rd[1] !== 1'b0; k++)
         apb(`APB_CTRL, 1'b0, 32'h0000_0000);
      link(`OFS_OUT_DIV, 1'b0, 16'h0000);
      check("init divider word", 16'h0800, rd[31:16]);
      $display("test reserved words done");
      for (k = 0; k < 13; k++)
      begin
         link(`OFS_OUT_DIV, 1'b1, {5'h01, 5'(k), 6'h00});
         check("divide ratio", div_tab[k], ratio);
      end
      link(`OFS_OUT_DIV, 1'b1, 16'h0B40);
      check("ratio error flag", 1, rd[1]);
      check("ratio kept", 8'hC0, ratio);
      apb(`APB_STATUS, 1'b1, 32'h0000_0002);
      apb(`APB_STATUS, 1'b0, 32'h0000_0000);
      check("ratio error cleared", 0, rd[1]);
      apb(8'h0C, 1'b1, 32'hFFFF_FFFF);
      check("apb slave error", 1, err);
      link(7'h50, 1'b0, 16'h0000);
      check("unmapped link read", 16'h0000, rd[31:16]);
      $display("test divider and errors done");
      link(`OFS_FS_DLY_A, 1'b1, 16'h0A15);
      link(`OFS_FS_DLY_B, 1'b1, 16'h3B1E);
      check("delay fields", {6'h2C, 6'h1E, 6'h28, 6'h15}, {dly[3], dly[2], dly[1], dly[0]});
      link(`OFS_CNT_HIGH, 1'b1, 16'h0000);
      link(`OFS_CNT_LOW, 1'b1, 16'h0003);
      check("count below minimum", 1, rd[2]);
      sync_run(3'h0, 3);
      sync_run(3'h2, 3);
      $display("test sync delay done");
      link(`OFS_FS_DIV, 1'b1, 16'h0003);
      link(`OFS_OUT_DIV, 1'b1, 16'h0800);
      link(`OFS_FS_CTRL, 1'b1, 16'h0048);
      period(12);
      link(`OFS_FS_CTRL, 1'b1, 16'h0088);
      period(24);
      link(`OFS_FS_CTRL, 1'b1, 16'h004C);
      repeat (30) @(posedge clk_sys_in);
      f0 = fs_cnt;
      pulses(60, 0);
      f0 = fs_cnt;
      apb(`APB_CTRL, 1'b1, 32'h0000_0001);
      pulses(60, 1);
      apb(`APB_CTRL, 1'b1, 32'h0000_0000);
      link(`OFS_FS_CTRL, 1'b1, 16'h0058);
      repeat (30) @(posedge clk_sys_in);
      f0 = fs_cnt;
      apb(`APB_CTRL, 1'b1, 32'h0000_0001);
      pulses(120, 3);
      $display("test frame sync done");
      results();
   end
endmodule
`default_nettype wire
